// file: logic/ifeb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ifeb_bank
   import ifeb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire ifeb_bus_req_s bus_req,
   output logic [15:0] rdata,
   input wire logic [15:0] event_three,
   input wire logic [15:0] event_four,
   input wire logic [15:0] event_five,
   input wire logic [15:0] flag_zero_in,
   input wire logic [15:0] enable_three_in,
   input wire logic [15:0] enable_four_in,
   input wire logic [15:0] enable_five_in,
   output logic [15:0] flag_three,
   output logic [15:0] flag_four,
   output logic [15:0] flag_five,
   output logic [15:0] enable_zero,
   output logic [15:0] req_zero,
   output logic [15:0] req_three,
   output logic [15:0] req_four,
   output logic [15:0] req_five,
   output logic irq
);
   typedef struct packed {
      logic [15:0] enable_zero;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic [15:0] rdata;
      logic [15:0] req_zero;
      logic [15:0] req_three;
      logic [15:0] req_four;
      logic [15:0] req_five;
      logic irq;
   } ifeb_state_s;

   ifeb_state_s state;
   ifeb_state_s next_state;

   function automatic logic wr_hit(input ifeb_bus_req_s req, input logic [3:0] off);
      wr_hit = req.wr && (req.addr == off);
   endfunction

   function automatic logic rd_hit(input ifeb_bus_req_s req, input logic [3:0] off);
      rd_hit = req.rd && (req.addr == off);
   endfunction

   // flag registers: write stores, source event sets, set beats clear
   ifeb_flag_reg #(.IMPL(IMPL_FLAG_THREE)) u_flag_three
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_hit(bus_req, OFF_FLAG_THREE)),
      .wdata(bus_req.wdata),
      .event_in(event_three),
      .flag(flag_three)
   );

   ifeb_flag_reg #(.IMPL(IMPL_FLAG_FOUR)) u_flag_four
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_hit(bus_req, OFF_FLAG_FOUR)),
      .wdata(bus_req.wdata),
      .event_in(event_four),
      .flag(flag_four)
   );

   ifeb_flag_reg #(.IMPL(IMPL_FLAG_FIVE)) u_flag_five
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_hit(bus_req, OFF_FLAG_FIVE)),
      .wdata(bus_req.wdata),
      .event_in(event_five),
      .flag(flag_five)
   );

   logic [3:0] irq_events;
   logic [3:0] irq_clear;
   logic [15:0] gate_zero;

   always_comb
   begin
      next_state = state;
      gate_zero = flag_zero_in & state.enable_zero;
      irq_events = 4'h0;
      irq_events[IRQ_FLAG_THREE] = |(event_three & IMPL_FLAG_THREE);
      irq_events[IRQ_FLAG_FOUR] = |(event_four & IMPL_FLAG_FOUR);
      irq_events[IRQ_FLAG_FIVE] = |(event_five & IMPL_FLAG_FIVE);
      // only a newly passing request counts, not one that keeps standing
      irq_events[IRQ_GROUP_ZERO] = |(gate_zero & ~state.req_zero);
      irq_clear = 4'h0;

      if (wr_hit(bus_req, OFF_ENABLE_ZERO))
      begin
         next_state.enable_zero = bus_req.wdata & IMPL_ENABLE_ZERO;
      end
      if (wr_hit(bus_req, OFF_IRQ_MASK))
      begin
         next_state.irq_mask = bus_req.wdata[3:0];
      end
      if (wr_hit(bus_req, OFF_IRQ_STATUS))
      begin
         irq_clear = bus_req.wdata[3:0];
      end
      // sticky status: a new event beats a write-one clear
      next_state.irq_status = (state.irq_status & ~irq_clear) | irq_events;

      // forwarded requests: flag and enable both high
      next_state.req_zero = gate_zero;
      next_state.req_three = flag_three & enable_three_in;
      next_state.req_four = flag_four & enable_four_in;
      next_state.req_five = flag_five & enable_five_in;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);

      // read data stands only in the cycle after the strobe
      next_state.rdata = 16'h0000;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            OFF_FLAG_THREE: next_state.rdata = flag_three & IMPL_FLAG_THREE;
            OFF_FLAG_FOUR: next_state.rdata = flag_four & IMPL_FLAG_FOUR;
            OFF_FLAG_FIVE: next_state.rdata = flag_five & IMPL_FLAG_FIVE;
            OFF_ENABLE_ZERO: next_state.rdata = state.enable_zero;
            OFF_IRQ_STATUS: next_state.rdata = {12'h000, state.irq_status};
            OFF_IRQ_MASK: next_state.rdata = {12'h000, state.irq_mask};
            default: next_state.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state.enable_zero <= RST_ENABLE;
         state.irq_status <= RST_IRQ;
         state.irq_mask <= RST_IRQ;
         state.rdata <= 16'h0000;
         state.req_zero <= 16'h0000;
         state.req_three <= 16'h0000;
         state.req_four <= 16'h0000;
         state.req_five <= 16'h0000;
         state.irq <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign enable_zero = state.enable_zero;
   assign req_zero = state.req_zero;
   assign req_three = state.req_three;
   assign req_four = state.req_four;
   assign req_five = state.req_five;
   assign irq = state.irq;

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd_at(logic [3:0] off);
      bus_req.rd && bus_req.addr == off;
   endsequence

   sequence s_wr_at(logic [3:0] off);
      bus_req.wr && bus_req.addr == off;
   endsequence

   property p_unimpl_zero;
      ((flag_three & ~IMPL_FLAG_THREE) == 16'h0000)
         && ((flag_four & ~IMPL_FLAG_FOUR) == 16'h0000)
         && ((flag_five & ~IMPL_FLAG_FIVE) == 16'h0000)
         && ((enable_zero & ~IMPL_ENABLE_ZERO) == 16'h0000);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented bit reads one");

   property p_calendar_set;
      event_three[CALENDAR_EVENT_FLAG] |=> flag_three[CALENDAR_EVENT_FLAG];
   endproperty
   a_calendar_set: assert property (p_calendar_set)
      else $error("calendar request not recorded");

   property p_pin4_set;
      event_three[EXT_PIN4_FLAG] |=> flag_three[EXT_PIN4_FLAG];
   endproperty
   a_pin4_set: assert property (p_pin4_set)
      else $error("pin 4 request not recorded");

   property p_charge_set;
      event_four[CHARGE_TIME_FLAG] |=> flag_four[CHARGE_TIME_FLAG] ##1 flag_four[CHARGE_TIME_FLAG]
         || $past(bus_req.wr);
   endproperty
   a_charge_set: assert property (p_charge_set)
      else $error("charge-time flag not held");

   property p_capture_nine;
      event_five[CAPTURE_NINE_FLAG] |=> flag_five[CAPTURE_NINE_FLAG];
   endproperty
   a_capture_nine: assert property (p_capture_nine)
      else $error("capture 9 request not recorded");

   property p_uart_four_err;
      (event_five[UART_FOUR_ERROR_FLAG] and s_wr_at(OFF_FLAG_FIVE))
         |=> flag_five[UART_FOUR_ERROR_FLAG];
   endproperty
   a_uart_four_err: assert property (p_uart_four_err)
      else $error("clearing write lost a UART4 error request");

   property p_flag_hold;
      flag_three[I2C_TWO_SLAVE_FLAG] && !wr_hit(bus_req, OFF_FLAG_THREE)
         |=> flag_three[I2C_TWO_SLAVE_FLAG];
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag dropped without a write");

   property p_flag_quiet;
      !flag_four[LOW_VOLTAGE_FLAG] && !event_four[LOW_VOLTAGE_FLAG]
         && !(bus_req.wr && bus_req.wdata[LOW_VOLTAGE_FLAG])
         |=> !flag_four[LOW_VOLTAGE_FLAG];
   endproperty
   a_flag_quiet: assert property (p_flag_quiet)
      else $error("flag rose with no request");

   property p_enable_write;
      s_wr_at(OFF_ENABLE_ZERO)
         |=> enable_zero == ($past(bus_req.wdata) & IMPL_ENABLE_ZERO);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable register did not take write");

   property p_enable_readback;
      s_rd_at(OFF_ENABLE_ZERO) |=> rdata == $past(enable_zero) ##1 rdata == 16'h0000
         || $past(bus_req.rd);
   endproperty
   a_enable_readback: assert property (p_enable_readback)
      else $error("enable read data wrong");

   property p_adc_blocked;
      !enable_zero[ADC_DONE_ENABLE] |=> !req_zero[ADC_DONE_ENABLE];
   endproperty
   a_adc_blocked: assert property (p_adc_blocked)
      else $error("disabled A/D request forwarded");

   property p_pin0_pass;
      enable_zero[EXT_PIN0_ENABLE] && flag_zero_in[EXT_PIN0_ENABLE]
         |=> req_zero[EXT_PIN0_ENABLE];
   endproperty
   a_pin0_pass: assert property (p_pin0_pass)
      else $error("enabled pin 0 request not forwarded");

   property p_req_three;
      req_three[CALENDAR_EVENT_FLAG] |-> $past(flag_three[CALENDAR_EVENT_FLAG])
         && $past(enable_three_in[CALENDAR_EVENT_FLAG]);
   endproperty
   a_req_three: assert property (p_req_three)
      else $error("request forwarded without flag and enable");

   property p_pin3_set;
      event_three[EXT_PIN3_FLAG] |=> flag_three[EXT_PIN3_FLAG];
   endproperty
   a_pin3_set: assert property (p_pin3_set)
      else $error("pin 3 request not recorded");

   property p_i2c_two_set;
      event_three[I2C_TWO_MASTER_FLAG] |=> flag_three[I2C_TWO_MASTER_FLAG];
   endproperty
   a_i2c_two_set: assert property (p_i2c_two_set)
      else $error("I2C2 master request not recorded");

   property p_low_voltage_set;
      event_four[LOW_VOLTAGE_FLAG] |=> flag_four[LOW_VOLTAGE_FLAG];
   endproperty
   a_low_voltage_set: assert property (p_low_voltage_set)
      else $error("low-voltage request not recorded");

   property p_uart_err_set;
      event_four[UART_ONE_ERROR_FLAG] |=> flag_four[UART_ONE_ERROR_FLAG];
   endproperty
   a_uart_err_set: assert property (p_uart_err_set)
      else $error("UART1 error request not recorded");

   property p_spi_three_set;
      event_five[SPI_THREE_FAULT_FLAG] |=> flag_five[SPI_THREE_FAULT_FLAG];
   endproperty
   a_spi_three_set: assert property (p_spi_three_set)
      else $error("SPI3 fault request not recorded");

   property p_uart_three_set;
      event_five[UART_THREE_TX_FLAG] |=> flag_five[UART_THREE_TX_FLAG];
   endproperty
   a_uart_three_set: assert property (p_uart_three_set)
      else $error("UART3 transmit request not recorded");

   // a request in the write cycle may win, so only quiet cycles are checked
   property p_flag_write;
      (s_wr_at(OFF_FLAG_FOUR) and ((event_four & IMPL_FLAG_FOUR) == 16'h0000))
         |=> flag_four == ($past(bus_req.wdata) & IMPL_FLAG_FOUR);
   endproperty
   a_flag_write: assert property (p_flag_write)
      else $error("flag register did not take write");

   property p_flag_read;
      s_rd_at(OFF_FLAG_FIVE) |=> rdata == $past(flag_five);
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag read data wrong");

   property p_unmapped_read;
      bus_req.rd && (bus_req.addr > OFF_IRQ_MASK) |=> rdata == 16'h0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   property p_rdata_idle;
      !bus_req.rd |=> rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside its cycle");

   property p_req_four;
      req_four[LOW_VOLTAGE_FLAG] |-> $past(flag_four[LOW_VOLTAGE_FLAG])
         && $past(enable_four_in[LOW_VOLTAGE_FLAG]);
   endproperty
   a_req_four: assert property (p_req_four)
      else $error("low-voltage request forwarded without flag and enable");

   property p_req_five_blocked;
      !enable_five_in[CAPTURE_NINE_FLAG] |=> !req_five[CAPTURE_NINE_FLAG];
   endproperty
   a_req_five_blocked: assert property (p_req_five_blocked)
      else $error("disabled capture 9 request forwarded");

   property p_status_sticky;
      state.irq_status[IRQ_FLAG_FOUR]
         && !(wr_hit(bus_req, OFF_IRQ_STATUS) && bus_req.wdata[IRQ_FLAG_FOUR])
         |=> state.irq_status[IRQ_FLAG_FOUR];
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("status bit dropped without a clearing write");
endmodule
`default_nettype wire

// file: logic/ifeb_pkg.sv
`default_nettype none
package ifeb_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // register indices on the plain register port
   localparam logic [3:0] OFF_FLAG_THREE = 4'h0;
   localparam logic [3:0] OFF_FLAG_FOUR = 4'h1;
   localparam logic [3:0] OFF_FLAG_FIVE = 4'h2;
   localparam logic [3:0] OFF_ENABLE_ZERO = 4'h3;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h5;

   // reset values
   localparam logic [15:0] RST_FLAG = 16'h0000;
   localparam logic [15:0] RST_ENABLE = 16'h0000;
   localparam logic [3:0] RST_IRQ = 4'h0;

   // implemented bit positions of each register
   localparam logic [15:0] IMPL_FLAG_THREE = 16'h4066;
   localparam logic [15:0] IMPL_FLAG_FOUR = 16'h210e;
   localparam logic [15:0] IMPL_FLAG_FIVE = 16'h3fbe;
   localparam logic [15:0] IMPL_ENABLE_ZERO = 16'h3fef;

   // flag_status_three fields
   localparam int CALENDAR_EVENT_FLAG = 14;
   localparam int EXT_PIN4_FLAG = 6;
   localparam int EXT_PIN3_FLAG = 5;
   localparam int I2C_TWO_MASTER_FLAG = 2;
   localparam int I2C_TWO_SLAVE_FLAG = 1;
   // flag_status_four fields
   localparam int CHARGE_TIME_FLAG = 13;
   localparam int LOW_VOLTAGE_FLAG = 8;
   localparam int CRC_GENERATOR_FLAG = 3;
   localparam int UART_TWO_ERROR_FLAG = 2;
   localparam int UART_ONE_ERROR_FLAG = 1;
   // flag_status_five fields
   localparam int CAPTURE_NINE_FLAG = 13;
   localparam int COMPARE_NINE_FLAG = 12;
   localparam int SPI_THREE_EVENT_FLAG = 11;
   localparam int SPI_THREE_FAULT_FLAG = 10;
   localparam int UART_FOUR_TX_FLAG = 9;
   localparam int UART_FOUR_RX_FLAG = 8;
   localparam int UART_FOUR_ERROR_FLAG = 7;
   localparam int I2C_THREE_MASTER_FLAG = 5;
   localparam int I2C_THREE_SLAVE_FLAG = 4;
   localparam int UART_THREE_TX_FLAG = 3;
   localparam int UART_THREE_RX_FLAG = 2;
   localparam int UART_THREE_ERROR_FLAG = 1;
   // enable_control_zero fields
   localparam int ADC_DONE_ENABLE = 13;
   localparam int UART_ONE_TX_ENABLE = 12;
   localparam int UART_ONE_RX_ENABLE = 11;
   localparam int SPI_ONE_DONE_ENABLE = 10;
   localparam int SPI_ONE_FAULT_ENABLE = 9;
   localparam int TIMER_THREE_ENABLE = 8;
   localparam int TIMER_TWO_ENABLE = 7;
   localparam int COMPARE_TWO_ENABLE = 6;
   localparam int CAPTURE_TWO_ENABLE = 5;
   localparam int TIMER_ONE_ENABLE = 3;
   localparam int COMPARE_ONE_ENABLE = 2;
   localparam int CAPTURE_ONE_ENABLE = 1;
   localparam int EXT_PIN0_ENABLE = 0;

   // irq status and mask fields
   localparam int IRQ_FLAG_THREE = 0;
   localparam int IRQ_FLAG_FOUR = 1;
   localparam int IRQ_FLAG_FIVE = 2;
   localparam int IRQ_GROUP_ZERO = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ifeb_bus_req_s;
endpackage
`default_nettype wire

// file: logic/ifeb_flag_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ifeb_flag_reg
   import ifeb_pkg::*;
#(
   parameter logic [15:0] IMPL = 16'h0000
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   input wire logic [15:0] event_in,
   output logic [15:0] flag
);
   typedef struct packed {
      logic [15:0] value;
   } ifeb_flag_state_s;

   ifeb_flag_state_s state;
   ifeb_flag_state_s next_state;

   always_comb
   begin
      next_state = state;
      // software may set or clear any implemented flag
      if (wr_en)
      begin
         next_state.value = wdata & IMPL;
      end
      // a request in the same cycle as a clearing write still lands
      next_state.value = next_state.value | (event_in & IMPL);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state.value <= RST_FLAG;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign flag = state.value;
endmodule
`default_nettype wire

// file: bench/ifeb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifeb_src_model
   import ifeb_pkg::*;
(
   input wire logic fire,
   input wire logic [1:0] sel,
   input wire logic [3:0] bit_idx,
   output logic [15:0] event_three,
   output logic [15:0] event_four,
   output logic [15:0] event_five
);
   logic [15:0] one_hot;
   // a source asserts only its own bit, and only while fire is high
   assign one_hot = fire ? (16'h0001 << bit_idx) : 16'h0000;
   assign event_three = (sel == 2'h0) ? one_hot : 16'h0000;
   assign event_four = (sel == 2'h1) ? one_hot : 16'h0000;
   assign event_five = (sel == 2'h2) ? one_hot : 16'h0000;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top
   import ifeb_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   ifeb_bus_req_s bus_req = '0;
   logic [15:0] rdata, event_three, event_four, event_five, flag_zero_in;
   logic [15:0] enable_three_in, enable_four_in, enable_five_in;
   logic [15:0] flag_three, flag_four, flag_five, enable_zero;
   logic [15:0] req_zero, req_three, req_four, req_five;
   logic irq, fire;
   logic [1:0] sel;
   logic [3:0] bit_idx;
   int num_errors = 0;
   int total_checks = 0;
   // implemented bits per register, worked out from the bit lists
   logic [15:0] impl [4] = '{16'h4066, 16'h210e, 16'h3fbe, 16'h3fef};

   ifeb_src_model u_src (.fire(fire), .sel(sel), .bit_idx(bit_idx),
      .event_three(event_three), .event_four(event_four), .event_five(event_five));
   ifeb_bank u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .event_three(event_three), .event_four(event_four), .event_five(event_five),
      .flag_zero_in(flag_zero_in), .enable_three_in(enable_three_in),
      .enable_four_in(enable_four_in), .enable_five_in(enable_five_in),
      .flag_three(flag_three), .flag_four(flag_four), .flag_five(flag_five),
      .enable_zero(enable_zero), .req_zero(req_zero), .req_three(req_three),
      .req_four(req_four), .req_five(req_five), .irq(irq));

   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask

   task automatic pulse(input logic [1:0] s, input logic [3:0] b);
      @(posedge sys_clk);
      fire <= 1'b1;
      sel <= s;
      bit_idx <= b;
      @(posedge sys_clk);
      fire <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_reset();
      for (int a = 0; a < 7; a++)
         rd_chk(a[3:0], 16'h0000);
      settle(1);
      `CHK("rdata_idle", 16'h0000, rdata)
      `CHK("irq", 1'b0, irq)
   endtask

   task automatic t_regs();
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(i[3:0], 16'hffff);
         rd_chk(i[3:0], impl[i]);
         wr_reg(i[3:0], 16'h0000);
         rd_chk(i[3:0], 16'h0000);
      end
      wr_reg(4'h6, 16'hffff);
      rd_chk(4'h6, 16'h0000);
   endtask

   task automatic t_events();
      for (int g = 0; g < 3; g++)
      begin
         for (int b = 0; b < 16; b++)
            pulse(g[1:0], b[3:0]);
         settle(4);
         rd_chk(g[3:0], impl[g]);
         wr_reg(g[3:0], 16'h0000);
         rd_chk(g[3:0], 16'h0000);
      end
      wr_reg(OFF_FLAG_THREE, 16'h4066);
      fork
         wr_reg(OFF_FLAG_THREE, 16'h0000);
         pulse(2'h0, 4'he);
      join
      settle(1);
      `CHK("flag_three", 16'h4000, flag_three)
      wr_reg(OFF_FLAG_FIVE, 16'h3fbe);
      fork
         wr_reg(OFF_FLAG_FIVE, 16'h0000);
         pulse(2'h2, 4'h7);
      join
      settle(1);
      `CHK("flag_five", 16'h0080, flag_five)
   endtask

   task automatic t_enable();
      @(posedge sys_clk);
      flag_zero_in <= 16'hffff;
      for (int b = 0; b < 16; b++)
      begin
         wr_reg(OFF_ENABLE_ZERO, 16'h0001 << b);
         settle(2);
         `CHK("req_zero", (16'h0001 << b) & 16'h3fef, req_zero)
      end
      wr_reg(OFF_ENABLE_ZERO, 16'h0000);
      settle(2);
      `CHK("req_zero", 16'h0000, req_zero)
      @(posedge sys_clk);
      enable_three_in <= 16'h4000;
      enable_four_in <= 16'hffff;
      // bit 7 passes, bit 13 is held back by its enable
      enable_five_in <= 16'hdfff;
      pulse(2'h0, 4'h2);
      pulse(2'h1, 4'h8);
      pulse(2'h2, 4'hd);
      settle(2);
      `CHK("req_three", 16'h4000, req_three)
      `CHK("req_four", 16'h0100, req_four)
      `CHK("req_five", 16'h0080, req_five)
   endtask

   task automatic t_irq();
      rd_chk(OFF_IRQ_STATUS, 16'h000f);
      wr_reg(OFF_IRQ_STATUS, 16'h000f);
      wr_reg(OFF_IRQ_MASK, 16'hfff1);
      rd_chk(OFF_IRQ_MASK, 16'h0001);
      settle(1);
      `CHK("irq", 1'b0, irq)
      pulse(2'h1, 4'h3);
      settle(1);
      `CHK("irq", 1'b0, irq)
      rd_chk(OFF_IRQ_STATUS, 16'h0002);
      pulse(2'h0, 4'h1);
      settle(1);
      `CHK("irq", 1'b1, irq)
      wr_reg(OFF_IRQ_STATUS, 16'h0001);
      settle(1);
      `CHK("irq", 1'b0, irq)
      rd_chk(OFF_IRQ_STATUS, 16'h0002);
   endtask

   task automatic t_midreset();
      wr_reg(OFF_ENABLE_ZERO, 16'h2001);
      wr_reg(OFF_IRQ_MASK, 16'h000f);
      settle(1);
      `CHK("irq", 1'b1, irq)
      // reset in mid-run must clear everything software set
      @(posedge sys_clk);
      rst_n <= 1'b0;
      settle(2);
      `CHK("flag_three", 16'h0000, flag_three)
      `CHK("flag_four", 16'h0000, flag_four)
      `CHK("flag_five", 16'h0000, flag_five)
      `CHK("enable_zero", 16'h0000, enable_zero)
      `CHK("req_zero", 16'h0000, req_zero)
      `CHK("irq", 1'b0, irq)
      @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(OFF_IRQ_MASK, 16'h0000);
      rd_chk(OFF_IRQ_STATUS, 16'h0000);
      wr_reg(OFF_ENABLE_ZERO, 16'hffff);
      rd_chk(OFF_ENABLE_ZERO, 16'h3fef);
   endtask

   initial
   begin
      fire = 1'b0;
      sel = 2'h0;
      bit_idx = 4'h0;
      flag_zero_in = 16'h0000;
      enable_three_in = 16'h0000;
      enable_four_in = 16'h0000;
      enable_five_in = 16'h0000;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_events();
      t_enable();
      t_irq();
      t_midreset();
      complete_run();
   end

   // whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
